//--- shared/bef_pkg.sv
// Contract
// - Identifier readout selected by select voltage on address bit nine.
// - Host holds all other address lines low during identifier readout; bit zero follows the request address to pick the code.
// - Write only with select and strobe low and output enable high.
// - Host ends erase with erase-verify; erase stops at that strobe rise.
// - Host programs every byte to all zeros before any chip erase.
// - After each erase host verifies every byte in order with erase-verify.
// - Host waits the recovery time after erase-verify before reading.
package bef_pkg;
  localparam int ADDR_W = 18;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'ha0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hc0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Timing, in ns and derived cycle counts at the 20 MHz clock
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 150;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 6000;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_NS = 10000000;
  localparam int ERASE_CYC = ERASE_NS / CLK_NS;
  localparam int PROG_NS = 10000;
  localparam int PROG_CYC = PROG_NS / CLK_NS;
  localparam int WAIT_W = 24;
  // Host operations
  typedef enum logic [2:0] {
    BEF_OP_READ = 3'b000,
    BEF_OP_PROGRAM = 3'b001,
    BEF_OP_ERASE = 3'b010,
    BEF_OP_ERASE_CHECK = 3'b011,
    BEF_OP_ID_READ = 3'b100,
    BEF_OP_RESET = 3'b101
  } bef_op_t;
  typedef struct packed {
    bef_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } bef_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic pass;
  } bef_rsp_t;
  // Bus phase for one pin cycle
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } bef_cyc_t;
endpackage

//--- design/bef_bus_cycle.sv
`timescale 1ns/1ns
// Runs one write or read cycle on the device pins
module bef_bus_cycle #(
  parameter int ADDR_W = bef_pkg::ADDR_W
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic start_i, // Start one cycle
  input wire bef_pkg::bef_cyc_t cyc_i, // Cycle kind, address, data
  input wire logic [7:0] dq_i, // Data pins in
  output logic done_o, // Cycle finished pulse
  output logic [7:0] rdata_o, // Captured read data
  output logic ce_n_o, // Chip select
  output logic oe_n_o, // Output enable
  output logic we_n_o, // Write strobe
  output logic [ADDR_W-1:0] addr_o, // Address pins
  output logic [7:0] dq_o, // Data pins out
  output logic dq_oe_n_o // Data drive enable, low drives
);
  typedef enum logic [1:0] {
    BEF_C_IDLE = 2'b00,
    BEF_C_SETUP = 2'b01,
    BEF_C_ACTIVE = 2'b10,
    BEF_C_END = 2'b11
  } bef_cst_t;
  bef_cst_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;

  // --------------------------------------------------------------
  // Pin sequencing
  // --------------------------------------------------------------
  // Address settles a cycle before the strobe falls so that the device
  // latches a stable address on the falling edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= BEF_C_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= 8'h00;
      dq_oe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        BEF_C_IDLE: begin
          if (start_i) begin
            wr_q <= cyc_i.wr;
            addr_o <= cyc_i.addr;
            dq_o <= cyc_i.data;
            dq_oe_n_o <= ~cyc_i.wr;
            st_q <= BEF_C_SETUP;
          end
        end
        BEF_C_SETUP: begin
          // Output enable stays high on writes
          ce_n_o <= 1'b0;
          we_n_o <= ~wr_q; // Address latched on this fall
          oe_n_o <= wr_q;
          cnt_q <= wr_q ? 8'(bef_pkg::STROBE_CYC) : 8'(bef_pkg::ACCESS_CYC);
          st_q <= BEF_C_ACTIVE;
        end
        BEF_C_ACTIVE: begin
          if (cnt_q <= 8'h01) begin
            if (!wr_q) begin
              rdata_o <= dq_i;
            end
            we_n_o <= 1'b1; // Data latched on this rise
            oe_n_o <= 1'b1;
            st_q <= BEF_C_END;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BEF_C_END: begin
          // Release select and data after the strobe for hold time
          ce_n_o <= 1'b1;
          dq_oe_n_o <= 1'b1;
          done_o <= 1'b1;
          st_q <= BEF_C_IDLE;
        end
        default: st_q <= BEF_C_IDLE;
      endcase
    end
  end
endmodule

//--- design/bef_host.sv
`timescale 1ns/1ns
// Host controller that sequences commands to a bulk-erase flash device
module bef_host #(
  parameter int ADDR_W = bef_pkg::ADDR_W,
  parameter int ERASE_CYC = bef_pkg::ERASE_CYC,
  parameter int RECOVER_CYC = bef_pkg::RECOVER_CYC,
  parameter int PROG_CYC = bef_pkg::PROG_CYC
) (
  input wire logic clk_i, // System clock, 20 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic req_valid_i, // Request present
  input wire bef_pkg::bef_req_t req_i, // Operation, address, data
  input wire logic supply_high_i, // Programming supply at high level
  input wire logic [7:0] dq_i, // Data pins in
  output logic req_ready_o, // Idle, request can be taken
  output logic rsp_valid_o, // Result pulse
  output bef_pkg::bef_rsp_t rsp_o, // Result data and check flag
  output logic busy_o, // Operation in progress
  output logic id_voltage_o, // Force select voltage on bit nine
  output logic ce_n_o, // Chip select
  output logic oe_n_o, // Output enable
  output logic we_n_o, // Write strobe
  output logic [ADDR_W-1:0] addr_o, // Address pins
  output logic [7:0] dq_o, // Data pins out
  output logic dq_oe_n_o // Data drive enable, low drives
);
  typedef enum logic [3:0] {
    BEF_IDLE = 4'b0000,
    BEF_CYC1 = 4'b0001,
    BEF_CYC2 = 4'b0010,
    BEF_WAIT = 4'b0011,
    BEF_CYC3 = 4'b0100,
    BEF_RECOVER = 4'b0101,
    BEF_CYC4 = 4'b0110,
    BEF_DONE = 4'b0111
  } bef_st_t;

  // Odd parity over a full byte, data bit seven included
  function automatic logic odd_parity(input logic [7:0] b);
    odd_parity = ^b;
  endfunction

  bef_st_t st_q;
  bef_pkg::bef_req_t req_q;
  logic [bef_pkg::WAIT_W-1:0] wait_q;
  logic start_q;
  bef_pkg::bef_cyc_t cyc_q;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  // --------------------------------------------------------------
  // Pin cycle engine
  // --------------------------------------------------------------
  bef_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start_q),
    .cyc_i(cyc_q),
    .dq_i(dq_i),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o)
  );

  // Commands need the high supply; without it only reads run
  function automatic logic needs_supply(input bef_pkg::bef_op_t op);
    needs_supply = (op != bef_pkg::BEF_OP_READ) &&
                   (op != bef_pkg::BEF_OP_ID_READ);
  endfunction

  // Build the pin cycle for a given step of the current operation
  function automatic bef_pkg::bef_cyc_t step_cyc(
    input bef_pkg::bef_req_t r, input logic [1:0] step);
    bef_pkg::bef_cyc_t c;
    c.wr = 1'b1;
    c.addr = '0;
    c.data = bef_pkg::CMD_READ;
    case (r.op)
      bef_pkg::BEF_OP_PROGRAM: begin
        // Setup, then address and byte, then verify code
        if (step == 2'd0) begin
          c.data = bef_pkg::CMD_PROGRAM;
        end else if (step == 2'd1) begin
          c.addr = r.addr;
          c.data = r.data;
        end else if (step == 2'd2) begin
          c.data = bef_pkg::CMD_PROGRAM_VERIFY;
        end else begin
          c.wr = 1'b0; // Latched address is read back
        end
      end
      bef_pkg::BEF_OP_ERASE: begin
        // Two erase codes, then erase-verify at address zero
        if (step == 2'd0 || step == 2'd1) begin
          c.data = bef_pkg::CMD_ERASE; // First one only arms
        end else if (step == 2'd2) begin
          c.data = bef_pkg::CMD_ERASE_VERIFY; // Ends erase
        end else begin
          c.wr = 1'b0;
        end
      end
      bef_pkg::BEF_OP_ERASE_CHECK: begin
        // Per-byte check, address latched with the command
        if (step == 2'd2) begin
          c.addr = r.addr;
          c.data = bef_pkg::CMD_ERASE_VERIFY;
        end else begin
          c.wr = 1'b0;
          c.addr = r.addr;
        end
      end
      bef_pkg::BEF_OP_RESET: begin
        c.data = bef_pkg::CMD_RESET; // Written twice
      end
      bef_pkg::BEF_OP_ID_READ: begin
        // Other address lines held low in this mode
        c.wr = 1'b0;
        c.addr = {{(ADDR_W-1){1'b0}}, r.addr[0]};
      end
      default: begin
        // Read code first, then the array read
        if (step == 2'd0) begin
          c.data = bef_pkg::CMD_READ;
        end else begin
          c.wr = 1'b0;
          c.addr = r.addr;
        end
      end
    endcase
    return c;
  endfunction

  // --------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------
  // Program and erase are always closed by their verify command, so the
  // device never keeps a pulse running once this host moves on.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= BEF_IDLE;
      req_q <= '0;
      wait_q <= '0;
      start_q <= 1'b0;
      cyc_q <= '0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
      busy_o <= 1'b0;
      id_voltage_o <= 1'b0;
    end else begin
      start_q <= 1'b0;
      rsp_valid_o <= 1'b0;
      case (st_q)
        BEF_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_q <= req_i;
            req_ready_o <= 1'b0;
            busy_o <= 1'b1;
            if (needs_supply(req_i.op) && !supply_high_i) begin
              // Refused: device ignores commands without the supply
              rsp_o <= '0;
              st_q <= BEF_DONE;
            end else if (req_i.op == bef_pkg::BEF_OP_ID_READ) begin
              id_voltage_o <= 1'b1;
              cyc_q <= step_cyc(req_i, 2'd3);
              start_q <= 1'b1;
              st_q <= BEF_CYC4;
            end else if (req_i.op == bef_pkg::BEF_OP_ERASE_CHECK) begin
              cyc_q <= step_cyc(req_i, 2'd2);
              start_q <= 1'b1;
              st_q <= BEF_CYC3;
            end else begin
              cyc_q <= step_cyc(req_i, 2'd0);
              start_q <= 1'b1;
              st_q <= BEF_CYC1;
            end
          end
        end
        BEF_CYC1: begin
          if (cyc_done) begin
            cyc_q <= step_cyc(req_q, 2'd1);
            start_q <= 1'b1;
            st_q <= BEF_CYC2;
          end
        end
        BEF_CYC2: begin
          if (cyc_done) begin
            if (req_q.op == bef_pkg::BEF_OP_PROGRAM) begin
              wait_q <= bef_pkg::WAIT_W'(PROG_CYC);
              st_q <= BEF_WAIT;
            end else if (req_q.op == bef_pkg::BEF_OP_ERASE) begin
              // Host timer matches the device cap
              wait_q <= bef_pkg::WAIT_W'(ERASE_CYC);
              st_q <= BEF_WAIT;
            end else begin
              rsp_o.data <= cyc_rdata;
              rsp_o.pass <= 1'b1;
              st_q <= BEF_DONE;
            end
          end
        end
        BEF_WAIT: begin
          if (wait_q <= bef_pkg::WAIT_W'(1)) begin
            cyc_q <= step_cyc(req_q, 2'd2);
            start_q <= 1'b1;
            st_q <= BEF_CYC3;
          end else begin
            wait_q <= wait_q - bef_pkg::WAIT_W'(1);
          end
        end
        BEF_CYC3: begin
          if (cyc_done) begin
            // Margin voltages settle before the verify read
            wait_q <= bef_pkg::WAIT_W'(RECOVER_CYC);
            st_q <= BEF_RECOVER;
          end
        end
        BEF_RECOVER: begin
          if (wait_q <= bef_pkg::WAIT_W'(1)) begin
            cyc_q <= step_cyc(req_q, 2'd3);
            start_q <= 1'b1;
            st_q <= BEF_CYC4;
          end else begin
            wait_q <= wait_q - bef_pkg::WAIT_W'(1);
          end
        end
        BEF_CYC4: begin
          if (cyc_done) begin
            rsp_o.data <= cyc_rdata;
            case (req_q.op)
              bef_pkg::BEF_OP_PROGRAM:
                rsp_o.pass <= (cyc_rdata == req_q.data);
              bef_pkg::BEF_OP_ID_READ:
                rsp_o.pass <= odd_parity(cyc_rdata);
              default:
                rsp_o.pass <= (cyc_rdata == bef_pkg::ERASED_BYTE);
            endcase
            id_voltage_o <= 1'b0;
            st_q <= BEF_DONE;
          end
        end
        BEF_DONE: begin
          rsp_valid_o <= 1'b1;
          busy_o <= 1'b0;
          st_q <= BEF_IDLE;
        end
        default: st_q <= BEF_IDLE;
      endcase
    end
  end
endmodule

//--- sim/bef_host_asserts.sv
`timescale 1ns/1ns
// ------
// Pin protocol checks for the flash host
// ------
module bef_host_asserts #(
  parameter int ADDR_W = bef_pkg::ADDR_W,
  parameter int ERASE_CYC = bef_pkg::ERASE_CYC,
  parameter int RECOVER_CYC = bef_pkg::RECOVER_CYC
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic req_valid_i, // Request
  input wire bef_pkg::bef_req_t req_i, // Request body
  input wire logic supply_high_i, // Supply high
  input wire logic req_ready_o, // Ready
  input wire logic rsp_valid_o, // Result pulse
  input wire bef_pkg::bef_rsp_t rsp_o, // Result
  input wire logic id_voltage_o, // Select voltage
  input wire logic ce_n_o, // Select pin
  input wire logic oe_n_o, // Output enable pin
  input wire logic we_n_o, // Write strobe pin
  input wire logic [ADDR_W-1:0] addr_o, // Address pins
  input wire logic [7:0] dq_o, // Data out
  input wire logic dq_oe_n_o // Data drive enable
);
  int cnt_q; // Cycles since last strobe
  logic [7:0] last_q; // Last byte written
  logic refused; // Command taken while supply is low
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  assign refused = req_valid_i && req_ready_o && !supply_high_i &&
    !(req_i.op inside {bef_pkg::BEF_OP_READ, bef_pkg::BEF_OP_ID_READ});
  // Saturate so a long idle stretch cannot wrap into a short one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
      last_q <= 8'h00;
    end else if (!we_n_o) begin
      cnt_q <= 0;
      last_q <= dq_o;
    end else if (cnt_q < 1000000) begin
      cnt_q <= cnt_q + 1;
    end
  end
  chk_write_pins: assert property (
    !we_n_o |-> !ce_n_o && oe_n_o) else $error("bad write pins");
  chk_write_drive: assert property (
    !we_n_o |-> !dq_oe_n_o) else $error("write without data drive");
  chk_latch_stable: assert property (
    $rose(we_n_o) |-> $stable(dq_o) && $stable(addr_o))
    else $error("data or address moved at strobe end");
  chk_read_release: assert property (
    !oe_n_o |-> dq_oe_n_o && we_n_o) else $error("contention on read");
  chk_refuse_quiet: assert property (
    refused |=> (ce_n_o && we_n_o) [*3]) else $error("pins moved");
  chk_refuse_answer: assert property (
    refused |-> ##[1:3] (rsp_valid_o && !rsp_o.pass && rsp_o.data == 8'h00))
    else $error("refusal not reported");
  chk_id_addr_low: assert property (
    id_voltage_o && !oe_n_o |-> addr_o[ADDR_W-1:1] == '0)
    else $error("upper address set in id read");
  chk_id_no_write: assert property (
    id_voltage_o |-> we_n_o) else $error("write during id read");
  chk_verify_wait: assert property (
    $fell(oe_n_o) && last_q == bef_pkg::CMD_ERASE_VERIFY |->
    cnt_q >= RECOVER_CYC) else $error("read too soon after verify");
  chk_erase_span: assert property (
    $fell(we_n_o) && dq_o == bef_pkg::CMD_ERASE_VERIFY &&
    last_q == bef_pkg::CMD_ERASE |-> cnt_q >= ERASE_CYC)
    else $error("erase ended early");
endmodule
bind bef_host bef_host_asserts #(.ADDR_W(ADDR_W), .ERASE_CYC(ERASE_CYC),
  .RECOVER_CYC(RECOVER_CYC)) u_chk (.clk_i, .rst_n_i, .req_valid_i, .req_i,
  .supply_high_i, .req_ready_o, .rsp_valid_o, .rsp_o, .id_voltage_o, .ce_n_o,
  .oe_n_o, .we_n_o, .addr_o, .dq_o, .dq_oe_n_o);

//--- sim/bef_flash_model.sv
`timescale 1ns/1ns
// ------
// Four-byte behavioural flash device
// ------
module bef_flash_model #(
  parameter int ADDR_W = bef_pkg::ADDR_W,
  parameter logic [7:0] MAKER_ID = 8'h8a, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h0b, // Arbitrary value
  parameter int REC_NS = 500,
  parameter int ACC_NS = 100
) (
  input wire logic ce_n_i, // Select
  input wire logic oe_n_i, // Output enable
  input wire logic we_n_i, // Write strobe
  input wire logic [ADDR_W-1:0] addr_i, // Address
  input wire logic [7:0] dq_i, // Bus level
  input wire logic id_voltage_i, // Select voltage on bit nine
  input wire logic supply_high_i, // Supply high
  output logic [7:0] dq_o, // Device data
  output logic viol_o // Host broke a rule
);
  logic [7:0] mem [4];
  logic [7:0] cmd_q, rd;
  logic [ADDR_W-1:0] wa_q, pa_q, ea_q;
  logic arm_q, ers_q, v_er, v_rd;
  realtime t_wr;
  // Factory erased, read mode at power-up
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {cmd_q, arm_q, ers_q, v_er, v_rd} = '0;
    t_wr = 0.0;
  end
  // Any supply transition drops back to read mode
  always @(supply_high_i) begin
    {cmd_q, arm_q, ers_q} = '0;
  end
  // Address taken at the later falling edge of strobe or select
  always @(negedge we_n_i) if (!ce_n_i && oe_n_i) wa_q = addr_i;
  always @(negedge ce_n_i) if (!we_n_i && oe_n_i) wa_q = addr_i;
  // Unmapped command latch; data taken at strobe rise
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && supply_high_i) begin
      if (arm_q) begin
        mem[wa_q[1:0]] = dq_i;
        pa_q = wa_q;
        arm_q = 1'b0;
      end else begin
        case (dq_i)
          8'h40: arm_q = 1'b1;
          8'h20: begin
            if (cmd_q == 8'h20) begin
              ers_q = 1'b1;
              foreach (mem[i]) if (mem[i] != 8'h00) v_er = 1'b1;
            end
            cmd_q = 8'h20;
          end
          8'ha0: begin
            if (ers_q) foreach (mem[i]) mem[i] = 8'hff;
            ers_q = 1'b0;
            ea_q = wa_q;
            cmd_q = 8'ha0;
            t_wr = $realtime;
          end
          default: cmd_q = dq_i;
        endcase
      end
    end
  end
  // Host must keep upper lines low and honour verify recovery
  always @(negedge oe_n_i) begin
    if (id_voltage_i && addr_i[ADDR_W-1:1] != '0) v_rd = 1'b1;
    if (cmd_q == 8'ha0 && $realtime - t_wr < REC_NS) v_rd = 1'b1;
  end
  // Read source follows the mode
  always_comb begin
    if (id_voltage_i || cmd_q inside {8'h80, 8'h90}) begin
      rd = addr_i[0] ? PART_ID : MAKER_ID;
    end else if (cmd_q == 8'hc0) begin
      rd = mem[pa_q[1:0]];
    end else if (cmd_q == 8'ha0) begin
      rd = mem[ea_q[1:0]];
    end else begin
      rd = mem[addr_i[1:0]];
    end
  end
  // Unselected, the bus shows the inverse so stale samples fail
  assign #ACC_NS dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
  assign viol_o = v_er | v_rd;
endmodule

//--- sim/test_bef_host.sv
`timescale 1ns/1ns
module test_bef_host;
  localparam logic [7:0] MAKER_ID = 8'h8a; // Arbitrary, odd parity
  localparam logic [7:0] PART_ID = 8'h0b; // Arbitrary, odd parity
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic supply_high_i = 1'b0;
  bef_pkg::bef_req_t req_i = '0;
  bef_pkg::bef_rsp_t rsp_o;
  logic req_ready_o, rsp_valid_o, busy_o, id_voltage_o, viol;
  logic ce_n_o, oe_n_o, we_n_o, dq_oe_n_o;
  logic [bef_pkg::ADDR_W-1:0] addr_o;
  logic [7:0] h_dq, m_dq, bus_dq;
  int miscompares = 0;
  int n_checks = 0;
  // Host level wins only while it drives
  assign bus_dq = !dq_oe_n_o ? h_dq : m_dq;
  always #25 clk_i = ~clk_i;
  // Short counts keep the run small
  bef_host #(.ERASE_CYC(100), .RECOVER_CYC(10), .PROG_CYC(20)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .supply_high_i(supply_high_i), .dq_i(bus_dq),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .busy_o(busy_o), .id_voltage_o(id_voltage_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(h_dq),
    .dq_oe_n_o(dq_oe_n_o));
  bef_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_flash (
    .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o),
    .dq_i(bus_dq), .id_voltage_i(id_voltage_o),
    .supply_high_i(supply_high_i), .dq_o(m_dq), .viol_o(viol));
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One request, held until taken, then the result pulse
  task automatic do_op(input bef_pkg::bef_op_t op, input int a,
                       input logic [7:0] d, output bef_pkg::bef_rsp_t r);
    int n;
    n = 0;
    req_i <= '{op: op, addr: a[bef_pkg::ADDR_W-1:0], data: d};
    req_valid_i <= 1'b1;
    do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 100);
    req_valid_i <= 1'b0;
    // Busy must stand from the edge after the take until the result
    @(posedge clk_i);
    check("busy during op", {7'h0, busy_o}, 8'h01);
    do @(posedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 3000);
    if (n >= 3000) begin
      miscompares++;
      $display("wrong value handshake expected 1 seen 0");
      give_verdict();
    end
    check("busy at result", {7'h0, busy_o}, 8'h00);
    r = rsp_o;
  endtask
  task automatic t_ident;
    bef_pkg::bef_rsp_t r;
    do_op(bef_pkg::BEF_OP_ID_READ, 0, 8'h00, r);
    check("maker id", r.data, MAKER_ID);
    check("id parity", {7'h0, r.pass}, 8'h01);
    do_op(bef_pkg::BEF_OP_ID_READ, 1, 8'h00, r);
    check("part id", r.data, PART_ID);
    check("part parity", {7'h0, r.pass}, 8'h01);
  endtask
  task automatic t_program;
    bef_pkg::bef_rsp_t r;
    do_op(bef_pkg::BEF_OP_PROGRAM, 1, 8'h5a, r);
    check("program check", r.data, 8'h5a);
    check("program pass", {7'h0, r.pass}, 8'h01);
    do_op(bef_pkg::BEF_OP_READ, 1, 8'h00, r);
    check("read back", r.data, 8'h5a);
    do_op(bef_pkg::BEF_OP_READ, 2, 8'h00, r);
    check("blank byte", r.data, 8'hff);
  endtask
  task automatic t_erase;
    bef_pkg::bef_rsp_t r;
    for (int i = 0; i < 4; i++) begin
      do_op(bef_pkg::BEF_OP_PROGRAM, i, 8'h00, r);
      check("zero fill", r.data, 8'h00);
    end
    do_op(bef_pkg::BEF_OP_ERASE, 0, 8'h00, r);
    check("erase byte", r.data, 8'hff);
    check("erase pass", {7'h0, r.pass}, 8'h01);
    // Address zero was checked by the erase itself; walk on upwards
    for (int i = 1; i < 4; i++) begin
      do_op(bef_pkg::BEF_OP_ERASE_CHECK, i, 8'h00, r);
      check("verify byte", r.data, 8'hff);
      check("verify pass", {7'h0, r.pass}, 8'h01);
    end
  endtask
  task automatic t_reset;
    bef_pkg::bef_rsp_t r;
    do_op(bef_pkg::BEF_OP_PROGRAM, 3, 8'h3c, r);
    do_op(bef_pkg::BEF_OP_RESET, 0, 8'h00, r);
    check("reset pass", {7'h0, r.pass}, 8'h01);
    do_op(bef_pkg::BEF_OP_READ, 3, 8'h00, r);
    check("read after reset", r.data, 8'h3c);
  endtask
  // Every command but read and identifier read is refused with the supply low, array intact
  task automatic t_refuse;
    bef_pkg::bef_rsp_t r;
    supply_high_i <= 1'b0;
    for (int i = 1; i < 6; i++) begin
      if (i == 4) continue;
      do_op(bef_pkg::bef_op_t'(i), 3, 8'h00, r);
      check("refused pass", {7'h0, r.pass}, 8'h00);
    end
    do_op(bef_pkg::BEF_OP_READ, 3, 8'h00, r);
    check("array kept", r.data, 8'h3c);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_ident;
    supply_high_i <= 1'b1;
    t_program;
    t_erase;
    t_reset;
    t_refuse;
    check("host faults", {7'h0, viol}, 8'h00);
    give_verdict;
  end
endmodule
